// ==== hdl/vtmm_core.sv ====
/*
 Vector selection, table read and banked data memory of the core.
 Assumes the sequencer drives one-cycle request strobes, and software
 reaches control and status over APB in the same pclk domain.
*/
//Contract
//- Reset loads the program counter with entry address zero.
//- Enabled low external interrupt with free stack vectors to 004.
//- Enabled timer 0 overflow with free stack vectors to 008.
//- Enabled timer 1 overflow with free stack vectors to 00C.
//- Enabled RTC time-out, RTC running, free stack, vectors to 014.
//- Enabled falling edge on port C line 0 vectors to 018.
//- Full stack keeps request pending until a return frees a level.
//- Table pointer gives low eight bits of table address.
//- Current page uses PC bits 11..8; last page forces them to F.
//- Low byte of fetched word goes to the named data location.
//- High byte of fetched word goes to table high register.
//- Table high register is read only, set only by table reads.
//- A table read takes two instruction cycles.
//- Data memory is eight bits wide, consecutive from zero.
//- Data memory is not cleared at power-on.
//- General memory has three banks chosen by the bank pointer.
//- Bank pointer 0, 1, 2 select banks 0, 1, 2.
//- Direct addressing always reaches bank 0.
//- First indirect port uses pointer zero, bank 0 only.
//- Banks 1 and 2 reached only by second port with bank pointer.
//- Special registers stay reachable whatever bank is chosen.
//- Unused special locations read as zero.
//- Bit set and clear change exactly one bit; on special registers the code clears the other bits.
//- Protected special registers ignore writes.
`timescale 1ns/1ps
module vtmm_core
	import vtmm_pkg::*;
#(
	parameter int GP_WORDS = 192
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources
	input wire logic ext_int_n,
	input wire logic tmr0_ovf,
	input wire logic tmr1_ovf,
	input wire logic rtc_timeout,
	input wire logic portc_line0,
	// Sequencer
	input wire logic [11:0] next_seq_pc,
	input wire logic pc_step,
	input wire logic ret_pulse,
	input wire logic call_pulse,
	output logic [11:0] pc,
	output logic vector_taken,
	// Table read
	input wire logic tab_req,
	input wire logic tab_last,
	input wire logic [7:0] tab_dest,
	output logic [11:0] prog_addr,
	input wire logic [15:0] prog_data,
	output logic tab_busy,
	// Data memory access
	input wire logic mem_req,
	input wire logic mem_wr,
	input wire logic [1:0] mem_op,
	input wire logic [2:0] mem_bit,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [4:0] int_en;
	logic rtc_run;
	logic [4:0] pend;
	logic [3:0] sp;
	logic portc_prev;
	logic [7:0] mp0, mp1, tblp, table_high_byte;
	logic [1:0] bank;
	logic [7:0] gp [3][GP_WORDS];
	vtmm_state_t state;
	logic [15:0] tab_word;
	logic apb_wr, stack_full, take;
	logic [4:0] grant;
	logic [11:0] vec;

	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign stack_full = (sp == 4'(STACK_LEVELS));
	assign tab_busy = (state != VTMM_IDLE);

	// Control register: interrupt enables and RTC run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en <= CTRL_RESET;
			rtc_run <= 1'b0;
		end else if (clk_en && apb_wr && paddr == REG_CTRL) begin
			int_en <= pwdata[4:0];
			rtc_run <= pwdata[5];
		end
	end

	// Pending flags; set wins over acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 5'h00;
			portc_prev <= 1'b1;
		end else if (clk_en) begin
			portc_prev <= portc_line0;
			pend <= (pend & ~grant) | {
				portc_prev && !portc_line0,
				rtc_timeout && rtc_run,
				tmr1_ovf,
				tmr0_ovf,
				!ext_int_n
			};
		end
	end

	// Lowest entry first; held while stack is full
	always_comb begin
		grant = 5'h00;
		vec = VEC_RESET;
		if (!stack_full && pc_step && !tab_busy) begin
			if (pend[0] && int_en[0]) begin
				grant = 5'h01;
				vec = VEC_EXT;
			end else if (pend[1] && int_en[1]) begin
				grant = 5'h02;
				vec = VEC_TMR0;
			end else if (pend[2] && int_en[2]) begin
				grant = 5'h04;
				vec = VEC_TMR1;
			end else if (pend[3] && int_en[3]) begin
				grant = 5'h08;
				vec = VEC_RTC;
			end else if (pend[4] && int_en[4]) begin
				grant = 5'h10;
				vec = VEC_MFI;
			end
		end
	end
	assign take = |grant;

	// Program counter and stack depth
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= VEC_RESET;
			sp <= 4'h0;
			vector_taken <= 1'b0;
		end else if (clk_en) begin
			vector_taken <= take;
			if (take) begin
				pc <= vec;
				sp <= sp + 4'h1;
			end else begin
				if (pc_step && !tab_busy)
					pc <= next_seq_pc;
				if (call_pulse && !stack_full)
					sp <= sp + 4'h1;
				else if (ret_pulse && sp != 4'h0)
					sp <= sp - 4'h1;
			end
		end
	end

	// Table address
	assign prog_addr = {tab_last ? LAST_PAGE : pc[11:8], tblp};

	// Two-cycle table read sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= VTMM_IDLE;
			tab_word <= 16'h0000;
		end else if (clk_en) begin
			case (state)
				VTMM_IDLE: begin
					if (tab_req)
						state <= VTMM_TAB1;
				end
				VTMM_TAB1: begin
					tab_word <= prog_data;
					state <= VTMM_TAB2;
				end
				VTMM_TAB2: state <= VTMM_IDLE;
				default: state <= VTMM_IDLE;
			endcase
		end
	end

	// Address resolution
	logic [7:0] eff_addr;
	logic [1:0] eff_bank;
	always_comb begin
		eff_addr = mem_addr;
		eff_bank = 2'd0;
		if (mem_addr == ADR_IND0) begin
			eff_addr = mp0;
		end else if (mem_addr == ADR_IND1) begin
			eff_addr = mp1;
			eff_bank = (bank > 2'd2) ? 2'd0 : bank;
		end
	end

	logic is_gp, do_wr, tab_wr;
	logic [7:0] wr_addr, cur, wval;
	logic [1:0] wr_bank;
	assign tab_wr = (state == VTMM_TAB2);
	assign wr_addr = tab_wr ? tab_dest : eff_addr;
	assign wr_bank = tab_wr ? 2'd0 : eff_bank;
	// Special area independent of bank
	assign is_gp = (wr_addr >= GP_BASE);
	assign do_wr = tab_wr || (mem_req && (mem_wr || mem_op != 2'd0));

	always_comb begin
		cur = is_gp ? gp[wr_bank][wr_addr - GP_BASE] : 8'h00;
		case (mem_op)
			2'd1: wval = cur | (8'h01 << mem_bit);
			2'd2: wval = cur & ~(8'h01 << mem_bit);
			default: wval = mem_wdata;
		endcase
		if (tab_wr)
			wval = tab_word[7:0];
	end

	// General memory, not initialised
	always_ff @(posedge pclk) begin
		if (clk_en && do_wr && is_gp)
			gp[wr_bank][wr_addr - GP_BASE] <= wval;
	end

	// Special registers; table high byte writable only by hardware
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mp0 <= 8'h00;
			mp1 <= 8'h00;
			bank <= 2'd0;
			tblp <= 8'h00;
			table_high_byte <= 8'h00;
		end else if (clk_en) begin
			if (tab_wr)
				table_high_byte <= tab_word[15:8];
			if (do_wr && !is_gp) begin
				case (wr_addr)
					ADR_MP0: mp0 <= wval;
					ADR_MP1: mp1 <= wval;
					ADR_BANK: bank <= wval[1:0];
					ADR_TBLP: tblp <= wval;
					default: ;
				endcase
			end
		end
	end

	// Read path, unused special bytes give zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mem_rdata <= 8'h00;
		else if (clk_en && mem_req && !mem_wr) begin
			if (eff_addr >= GP_BASE)
				mem_rdata <= gp[eff_bank][eff_addr - GP_BASE];
			else case (eff_addr)
				ADR_MP0: mem_rdata <= mp0;
				ADR_MP1: mem_rdata <= mp1;
				ADR_BANK: mem_rdata <= {6'h00, bank};
				ADR_TBLP: mem_rdata <= tblp;
				ADR_TABLE_HIGH_BYTE: mem_rdata <= table_high_byte;
				default: mem_rdata <= 8'h00;
			endcase
		end
	end

	// APB read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite) begin
			case (paddr)
				REG_CTRL: prdata <= {26'h0, rtc_run, int_en};
				REG_STATUS: prdata <= {22'h0, stack_full, sp, pend};
				REG_PC: prdata <= {20'h0, pc};
				REG_TABLE: prdata <= {16'h0, table_high_byte, tblp};
				REG_BANKS: prdata <= {22'h0, bank, mp1[7:0]};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	property p_stack_hold;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		stack_full |=> !vector_taken;
	endproperty
	a_stack_hold: assert property (p_stack_hold)
		else $error("vector taken with full stack");

	property p_last_page;
		@(posedge pclk) disable iff (!presetn)
		tab_last |-> prog_addr[11:8] == 4'hF && prog_addr[7:0] == tblp;
	endproperty
	a_last_page: assert property (p_last_page)
		else $error("last page address wrong");

	property p_tab_two;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		(state == VTMM_IDLE && tab_req) |=> tab_busy ##1 tab_busy
			##1 !tab_busy;
	endproperty
	a_tab_two: assert property (p_tab_two)
		else $error("table read not two cycles");

	property p_table_high_byte_load;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		tab_wr |=> table_high_byte == $past(tab_word[15:8]);
	endproperty
	a_table_high_byte_load: assert property (p_table_high_byte_load)
		else $error("table high byte not loaded");

	property p_table_high_byte_hold;
		@(posedge pclk) disable iff (!presetn)
		!tab_wr |=> $stable(table_high_byte);
	endproperty
	a_table_high_byte_hold: assert property (p_table_high_byte_hold)
		else $error("table high byte changed without read");

	property p_prio;
		@(posedge pclk) disable iff (!presetn)
		(take && pend[0] && int_en[0]) |-> vec == VEC_EXT;
	endproperty
	a_prio: assert property (p_prio)
		else $error("priority order wrong");

	property p_vec_load;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		take |=> pc == $past(vec) && vector_taken;
	endproperty
	a_vec_load: assert property (p_vec_load)
		else $error("vector not loaded");

	property p_ind0_bank;
		@(posedge pclk) disable iff (!presetn)
		(mem_addr == ADR_IND0) |-> eff_bank == 2'd0 && eff_addr == mp0;
	endproperty
	a_ind0_bank: assert property (p_ind0_bank)
		else $error("first indirect port left bank 0");

	property p_direct_bank;
		@(posedge pclk) disable iff (!presetn)
		(mem_addr != ADR_IND1) |-> eff_bank == 2'd0;
	endproperty
	a_direct_bank: assert property (p_direct_bank)
		else $error("direct access left bank 0");

	// Reserved gap between special registers and general memory
	property p_unused_zero;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		(mem_req && !mem_wr && eff_addr > ADR_TABLE_HIGH_BYTE && eff_addr < GP_BASE)
			|=> mem_rdata == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused special byte not zero");

	c_vector: cover property (@(posedge pclk) take);
	c_tab_last: cover property (@(posedge pclk) tab_wr && tab_last);
	c_full_wait: cover property (@(posedge pclk)
		stack_full && |pend ##1 ret_pulse);
	c_bank2: cover property (@(posedge pclk)
		mem_req && mem_addr == ADR_IND1 && bank == 2'd2);
endmodule

// ==== hdl/vtmm_pkg.sv ====
/*
 Constants for the vector table and data memory map block.
 Assumes a single 100 MHz clock domain shared with the APB slave.
*/
package vtmm_pkg;
	// Program memory entry addresses
	localparam logic [11:0] VEC_RESET = 12'h000;
	localparam logic [11:0] VEC_EXT = 12'h004;
	localparam logic [11:0] VEC_TMR0 = 12'h008;
	localparam logic [11:0] VEC_TMR1 = 12'h00C;
	localparam logic [11:0] VEC_RTC = 12'h014;
	localparam logic [11:0] VEC_MFI = 12'h018;
	localparam logic [3:0] LAST_PAGE = 4'hF;
	localparam int STACK_LEVELS = 8;
	// Special area addresses
	localparam logic [7:0] ADR_IND0 = 8'h00;
	localparam logic [7:0] ADR_MP0 = 8'h01;
	localparam logic [7:0] ADR_IND1 = 8'h02;
	localparam logic [7:0] ADR_MP1 = 8'h03;
	localparam logic [7:0] ADR_BANK = 8'h04;
	localparam logic [7:0] ADR_TBLP = 8'h07;
	localparam logic [7:0] ADR_TABLE_HIGH_BYTE = 8'h08;
	localparam logic [7:0] GP_BASE = 8'h40;
	localparam logic [7:0] GP_LAST = 8'hFF;
	// APB register offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_PC = 12'h008;
	localparam logic [11:0] REG_TABLE = 12'h00C;
	localparam logic [11:0] REG_BANKS = 12'h010;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	typedef enum logic [1:0] {
		VTMM_IDLE = 2'b00,
		VTMM_TAB1 = 2'b01,
		VTMM_TAB2 = 2'b10
	} vtmm_state_t;
endpackage

// ==== dv/vtmm_prog_model.sv ====
/*
 Program memory model facing the table read port.
 Assumes the core samples prog_data while its table read is busy.
*/
`timescale 1ns/1ps
module vtmm_prog_model (
	// Program memory port
	input wire logic [11:0] prog_addr,
	output logic [15:0] prog_data
);
	// High byte shows page and pointer low nibble, low byte scrambles pointer
	assign prog_data = {prog_addr[11:8], prog_addr[3:0],
		prog_addr[7:0] ^ 8'h5A};
endmodule

// ==== dv/tb.sv ====
/*
 Self-checking bench: reset, vectors, stack, table reads, banks.
 Assumes the program memory model and APB in the pclk domain.
*/
`timescale 1ns/1ps
module tb;
	import vtmm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, next_seq_pc, pc, prog_addr;
	logic [31:0] pwdata, prdata, rd;
	logic ext_int_n, tmr0_ovf, tmr1_ovf, rtc_timeout, portc_line0;
	logic pc_step, ret_pulse, call_pulse, vector_taken;
	logic clk_en;
	logic tab_req, tab_last, tab_busy, mem_req, mem_wr;
	logic [1:0] mem_op;
	logic [2:0] mem_bit;
	logic [7:0] tab_dest, mem_addr, mem_wdata, mem_rdata, d;
	logic [15:0] prog_data;
	int bad_count, num_checks;

	vtmm_core u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_int_n(ext_int_n),
		.tmr0_ovf(tmr0_ovf),
		.tmr1_ovf(tmr1_ovf),
		.rtc_timeout(rtc_timeout),
		.portc_line0(portc_line0),
		.next_seq_pc(next_seq_pc),
		.pc_step(pc_step),
		.ret_pulse(ret_pulse),
		.call_pulse(call_pulse),
		.pc(pc),
		.vector_taken(vector_taken),
		.tab_req(tab_req),
		.tab_last(tab_last),
		.tab_dest(tab_dest),
		.prog_addr(prog_addr),
		.prog_data(prog_data),
		.tab_busy(tab_busy),
		.mem_req(mem_req),
		.mem_wr(mem_wr),
		.mem_op(mem_op),
		.mem_bit(mem_bit),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata)
	);
	vtmm_prog_model u_prog (
		.prog_addr(prog_addr),
		.prog_data(prog_data)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict;
		end else begin
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task mem(input logic wr, input logic [1:0] op, input logic [2:0] b,
		input logic [7:0] a, input logic [7:0] wd);
		@(posedge pclk);
		mem_req <= 1'b1;
		mem_wr <= wr;
		mem_op <= op;
		mem_bit <= b;
		mem_addr <= a;
		mem_wdata <= wd;
		@(posedge pclk);
		mem_req <= 1'b0;
		#1 d = mem_rdata;
	endtask

	task step(input logic [11:0] exp);
		@(posedge pclk);
		pc_step <= 1'b1;
		@(posedge pclk);
		pc_step <= 1'b0;
		#1 chk(pc, exp);
		chk(vector_taken, exp != next_seq_pc);
	endtask

	task rst(input int n);
		presetn <= 1'b0;
		repeat (n) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task t_reset;
		chk(pc, VEC_RESET);
		apb(1'b0, REG_PC, 32'h0);
		chk(rd[11:0], VEC_RESET);
		apb(1'b1, REG_CTRL, 32'h0000003F);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd[5:0], 6'h3F);
		apb(1'b0, 12'hFFC, 32'h0);
		chk(rd, 32'h0);
		chk(pslverr, 1'b0);
	endtask

	task t_prio;
		@(posedge pclk);
		ext_int_n <= 1'b0;
		tmr0_ovf <= 1'b1;
		tmr1_ovf <= 1'b1;
		rtc_timeout <= 1'b1;
		portc_line0 <= 1'b0;
		@(posedge pclk);
		ext_int_n <= 1'b1;
		tmr0_ovf <= 1'b0;
		tmr1_ovf <= 1'b0;
		rtc_timeout <= 1'b0;
		step(VEC_EXT);
		step(VEC_TMR0);
		step(VEC_TMR1);
		step(VEC_RTC);
		step(VEC_MFI);
		step(next_seq_pc);
	endtask

	task t_stack;
		rst(2);
		apb(1'b1, REG_CTRL, 32'h00000002);
		@(posedge pclk);
		portc_line0 <= 1'b1;
		call_pulse <= 1'b1;
		repeat (8) @(posedge pclk);
		call_pulse <= 1'b0;
		tmr0_ovf <= 1'b1;
		@(posedge pclk);
		tmr0_ovf <= 1'b0;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[9], 1'b1);
		chk(rd[1], 1'b1);
		step(next_seq_pc);
		@(posedge pclk);
		ret_pulse <= 1'b1;
		@(posedge pclk);
		ret_pulse <= 1'b0;
		step(VEC_TMR0);
		step(next_seq_pc);
	endtask

	task t_table(input logic last, input logic [3:0] page);
		int n;
		n = 0;
		mem(1'b1, 2'd0, 3'd0, ADR_TBLP, 8'h37);
		@(posedge pclk);
		tab_req <= 1'b1;
		tab_last <= last;
		tab_dest <= 8'h50;
		repeat (5) begin
			@(posedge pclk);
			tab_req <= 1'b0;
			#1;
			if (tab_busy === 1'b1) begin
				n++;
				chk(prog_addr, {page, 8'h37});
			end
		end
		chk(n, 2);
		mem(1'b0, 2'd0, 3'd0, 8'h50, 8'h00);
		chk(d, 8'h37 ^ 8'h5A);
		mem(1'b0, 2'd0, 3'd0, ADR_TABLE_HIGH_BYTE, 8'h00);
		chk(d, {page, 4'h7});
		mem(1'b1, 2'd0, 3'd0, ADR_TABLE_HIGH_BYTE, 8'h00);
		mem(1'b0, 2'd0, 3'd0, ADR_TABLE_HIGH_BYTE, 8'h00);
		chk(d, {page, 4'h7});
		apb(1'b1, REG_TABLE, 32'h0);
		apb(1'b0, REG_TABLE, 32'h0);
		chk(rd[15:0], {page, 4'h7, 8'h37});
	endtask

	task t_banks;
		mem(1'b1, 2'd0, 3'd0, ADR_MP1, 8'h60);
		mem(1'b1, 2'd0, 3'd0, ADR_BANK, 8'h01);
		mem(1'b1, 2'd0, 3'd0, ADR_IND1, 8'h11);
		mem(1'b1, 2'd0, 3'd0, ADR_BANK, 8'h02);
		mem(1'b1, 2'd0, 3'd0, ADR_IND1, 8'h22);
		mem(1'b1, 2'd0, 3'd0, 8'h60, 8'h33);
		mem(1'b0, 2'd0, 3'd0, 8'h60, 8'h00);
		chk(d, 8'h33);
		mem(1'b1, 2'd0, 3'd0, ADR_MP0, 8'h60);
		mem(1'b0, 2'd0, 3'd0, ADR_IND0, 8'h00);
		chk(d, 8'h33);
		mem(1'b0, 2'd0, 3'd0, ADR_IND1, 8'h00);
		chk(d, 8'h22);
		mem(1'b0, 2'd0, 3'd0, ADR_MP1, 8'h00);
		chk(d, 8'h60);
		mem(1'b1, 2'd0, 3'd0, ADR_BANK, 8'h01);
		mem(1'b0, 2'd0, 3'd0, ADR_IND1, 8'h00);
		chk(d, 8'h11);
		mem(1'b1, 2'd0, 3'd0, ADR_BANK, 8'h00);
		mem(1'b0, 2'd0, 3'd0, ADR_IND1, 8'h00);
		chk(d, 8'h33);
		mem(1'b1, 2'd0, 3'd0, ADR_BANK, 8'h03);
		mem(1'b0, 2'd0, 3'd0, ADR_IND1, 8'h00);
		chk(d, 8'h33);
		mem(1'b0, 2'd0, 3'd0, 8'h30, 8'h00);
		chk(d, 8'h00);
		mem(1'b1, 2'd0, 3'd0, 8'h45, 8'hA5);
		mem(1'b1, 2'd1, 3'd1, 8'h45, 8'h00);
		mem(1'b1, 2'd2, 3'd7, 8'h45, 8'h00);
		mem(1'b0, 2'd0, 3'd0, 8'h45, 8'h00);
		chk(d, 8'h27);
		@(posedge pclk);
		clk_en <= 1'b0;
		mem(1'b1, 2'd0, 3'd0, 8'h45, 8'h00);
		@(posedge pclk);
		clk_en <= 1'b1;
		mem(1'b0, 2'd0, 3'd0, 8'h45, 8'h00);
		chk(d, 8'h27);
	endtask

	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_int_n = 1'b1;
		tmr0_ovf = 1'b0;
		tmr1_ovf = 1'b0;
		rtc_timeout = 1'b0;
		portc_line0 = 1'b1;
		next_seq_pc = 12'h523;
		pc_step = 1'b0;
		ret_pulse = 1'b0;
		call_pulse = 1'b0;
		tab_req = 1'b0;
		tab_last = 1'b0;
		tab_dest = 8'h00;
		mem_req = 1'b0;
		mem_wr = 1'b0;
		mem_op = 2'd0;
		mem_bit = 3'd0;
		mem_addr = 8'h00;
		mem_wdata = 8'h00;
		rst(10);
		t_reset;
		t_prio;
		t_stack;
		t_table(1'b0, 4'h5);
		t_table(1'b1, LAST_PAGE);
		t_banks;
		give_verdict;
	end
endmodule
